// [t1e1_line_tx_rx_control.sv]
// Transmit capture, line configuration and clock-loss control of a channel.
// How it works
// [R1] Transmit data is sampled on each falling transmit clock edge.
// [R2] The 4-bit config code comes from pins or from a control register.
// [R3] E1 and DS1 codes pick pulse width, slicing and coder.
// [R4] DSX-1 codes, reserved code and the two tristate codes are decoded.
// [R5] Slicing is 65% for DS1, DSX-1 and tristate code f, 50% otherwise.
// [R6] The far side configures both channels for the same line rate.
// [R7] In register mode custom pulse shapes are downloaded and used.
// [R8] A missing transmit or reference clock tristates the driver.
// [R9] With the attenuator in transmit, loss trips after 170 to 182 cycles.
// [R10] Without it in transmit, loss trips after 4 to 12 cycles.
// [R11] A clock-lost flag is high while the driver is tristated by loss.
// [R12] The driver is released after four transmit clock cycles.
// [R13] After reset the driver waits for clocks, plus a code rewrite in register mode.
// [R14] Remote loopback ignores a missing transmit clock.
// [R15] Config, all-ones or loopback changes settle within 22 bit periods.
// [R16] Remote loopback allows a longer settling time.
// [R17] Long zero runs on the receive path are passed without squelch.
// [R18] Receive edge select comes from a pin or a register bit.
// [R19] Edge select low: data valid at rising edge; high: at falling.
// [R20] Both local loopback bits set force all-ones receive data; the code does so in register mode only, not from the pin.
// [R21] Attenuator location: receive, off, transmit, slow receive.
// [R22] The mode pin picks pin control low, register control high.
// [R23] Each clock is watched by counting edges of the other.
`timescale 1ns/1ps
module t1e1_line_tx_rx_control #(
  parameter int WAVE_DEPTH   = 32,
  parameter int STALL_CYCLES = 4096
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Avalon-MM register slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Control pins
  input  wire logic        registerModePin,
  input  wire logic [3:0]  lineConfigCodePin,
  input  wire logic        rxEdgeSelectPin,
  input  wire logic [1:0]  jitterFilterLocationPin,
  input  wire logic        transmitAllOnesPin,
  input  wire logic        localLoopbackPin,
  input  wire logic        remoteLoopbackPin,
  // System transmit side
  input  wire logic        txLineClock,
  input  wire logic        txPositiveRailData,
  input  wire logic        txNegativeRailData,
  input  wire logic        referenceClockIn,
  // Line driver side
  output logic             linePositive,
  output logic             lineNegative,
  output logic             lineDriverOutputsEnable,
  output logic      [3:0]  pulseShape,
  output logic      [8:0]  pulseWidthNs,
  output logic             sliceLevel65,
  output logic             coderB8zs,
  output logic             arbitraryWave,
  output logic      [7:0]  waveSample,
  output logic      [1:0]  jitterFilterLocation,
  output logic             txSettling,
  output logic             clockLostFlag,
  // Receive side
  input  wire logic        rxRecoveredClock,
  input  wire logic        rxPositiveIn,
  input  wire logic        rxNegativeIn,
  output logic             rxClockOut,
  output logic             rxPositiveRailData,
  output logic             rxNegativeRailData
);

  localparam int SYNC_W = 18;
  localparam int WIDX_W = $clog2(WAVE_DEPTH);

  if (WAVE_DEPTH < 2 || (WAVE_DEPTH & (WAVE_DEPTH - 1)) != 0) begin : g_bad
    $error("WAVE_DEPTH must be a power of two of at least 2");
  end

  // ==========================================================================
  // Input synchronisers
  logic [SYNC_W-1:0] syncA_ff;
  logic [SYNC_W-1:0] syncB_ff;
  logic [2:0]        clkDly_ff;

  wire logic       regMode;
  wire logic [3:0] cfgPinS;
  wire logic       edgePinS;
  wire logic [1:0] jaPinS;
  wire logic       taosPinS;
  wire logic       llbPinS;
  wire logic       rlbPinS;
  wire logic       txClkS;
  wire logic       txPosS;
  wire logic       txNegS;
  wire logic       refClkS;
  wire logic       rxClkS;
  wire logic       rxPosS;
  wire logic       rxNegS;

  always_ff @(posedge clk) begin
    syncA_ff  <= {registerModePin, lineConfigCodePin, rxEdgeSelectPin,
                  jitterFilterLocationPin, transmitAllOnesPin,
                  localLoopbackPin, remoteLoopbackPin, txLineClock,
                  txPositiveRailData, txNegativeRailData, referenceClockIn,
                  rxRecoveredClock, rxPositiveIn, rxNegativeIn};
    syncB_ff  <= syncA_ff;
    clkDly_ff <= {txClkS, refClkS, rxClkS};
  end

  assign {regMode, cfgPinS, edgePinS, jaPinS, taosPinS, llbPinS, rlbPinS,
          txClkS, txPosS, txNegS, refClkS, rxClkS, rxPosS, rxNegS} =
         syncB_ff;

  wire txFall  = clkDly_ff[2] && !txClkS;
  wire refRise = !clkDly_ff[1] && refClkS;
  wire rxRise  = !clkDly_ff[0] && rxClkS;
  wire rxFall  = clkDly_ff[0] && !rxClkS;

  // ==========================================================================
  // Control registers and effective controls
  logic [7:0]        ctrlA_ff;
  logic [7:0]        ctrlB_ff;
  logic              cfgWritten_ff;
  logic [7:0]        waveMem [WAVE_DEPTH];
  logic [WIDX_W-1:0] waveIdx_ff;

  t1e1_pkg::tx_ctrl_t  txCtrl;
  t1e1_pkg::tx_ctrl_t  txCtrlLast_ff;
  t1e1_pkg::line_cfg_t cfgDec;

  assign txCtrl = regMode ?
    {ctrlB_ff[t1e1_pkg::B_CODE_LSB +: 4], ctrlB_ff[t1e1_pkg::B_TRANSMIT_ALL_ONES_BIT],
     ctrlB_ff[t1e1_pkg::B_LLA_BIT], ctrlB_ff[t1e1_pkg::B_LLB_BIT]} :
    {cfgPinS, taosPinS, llbPinS, llbPinS}; // R2 R22

  wire edgeSel = regMode ? ctrlA_ff[t1e1_pkg::A_EDGE_BIT] : edgePinS; // R18
  wire [1:0] jaLoc = regMode ? ctrlA_ff[t1e1_pkg::A_JA_LSB +: 2]
                             : jaPinS; // R21
  wire remoteLoop = regMode ? (ctrlA_ff[t1e1_pkg::A_RLA_BIT] ||
                               ctrlA_ff[t1e1_pkg::A_RLB_BIT])
                            : rlbPinS;
  wire allOnes = regMode && txCtrl.llbA && txCtrl.llbB; // R20
  wire jaInTx  = jaLoc == t1e1_pkg::JA_TX; // R21

  config_decode u_decode (
    .code (txCtrl.code),
    .cfg  (cfgDec)
  );

  // ==========================================================================
  // Avalon-MM slave: one wait cycle, write lands on the accepting edge
  logic        waitreq_ff;
  logic [31:0] readdata_ff;
  logic [7:0]  status;

  wire req    = read || write;
  wire accept = !waitreq_ff;
  wire wrEn   = accept && write;
  wire [31:0] rdMux =
    (address == t1e1_pkg::CTRL_A_OFS)    ? {24'h000000, ctrlA_ff} :
    (address == t1e1_pkg::CTRL_B_OFS)    ? {24'h000000, ctrlB_ff} :
    (address == t1e1_pkg::STATUS_OFS)    ? {24'h000000, status} :
    (address == t1e1_pkg::WAVE_IDX_OFS)  ? 32'(waveIdx_ff) :
    (address == t1e1_pkg::WAVE_DATA_OFS) ? {24'h000000, waveMem[waveIdx_ff]} :
    32'h00000000;

  always_ff @(posedge clk) begin
    if (reset) begin
      waitreq_ff  <= 1'b1;
      readdata_ff <= 32'h00000000;
    end else begin
      waitreq_ff <= !(req && waitreq_ff);
      if (req && waitreq_ff) begin
        readdata_ff <= rdMux;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrlA_ff      <= t1e1_pkg::CTRL_A_RST;
      ctrlB_ff      <= t1e1_pkg::CTRL_B_RST;
      cfgWritten_ff <= 1'b0;
      waveIdx_ff    <= '0;
    end else if (wrEn) begin
      if (address == t1e1_pkg::CTRL_A_OFS) begin
        ctrlA_ff <= writedata[7:0];
      end else if (address == t1e1_pkg::CTRL_B_OFS) begin
        ctrlB_ff      <= writedata[7:0];
        cfgWritten_ff <= 1'b1; // R13
      end else if (address == t1e1_pkg::WAVE_IDX_OFS) begin
        waveIdx_ff <= writedata[WIDX_W-1:0];
      end else if (address == t1e1_pkg::WAVE_DATA_OFS && regMode) begin
        waveIdx_ff <= waveIdx_ff + 1'b1; // R7
      end
    end
  end

  // Sample memory has no reset; software downloads it before use.
  always_ff @(posedge clk) begin
    if (wrEn && regMode && address == t1e1_pkg::WAVE_DATA_OFS) begin
      waveMem[waveIdx_ff] <= writedata[7:0]; // R7
    end
  end

  // ==========================================================================
  // Clock loss detection and driver state
  logic                   txLost;
  logic                   refLost;
  logic [2:0]             txEdgeCnt_ff;
  logic                   clockLost_ff;
  logic                   driverEn_ff;
  t1e1_pkg::drv_state_t   drvState_ff;
  t1e1_pkg::drv_state_t   nxt_drvState;

  wire [7:0] txLimit = jaInTx ? t1e1_pkg::LOSS_LIMIT_JA
                              : t1e1_pkg::LOSS_LIMIT_DIRECT; // R9 R10

  clock_watch #(
    .LIMIT_W      (8),
    .STALL_CYCLES (STALL_CYCLES)
  ) u_tx_watch (
    .clk       (clk),
    .reset     (reset),
    .ownEdge   (txFall),
    .otherEdge (refRise),
    .limit     (txLimit),
    .lost      (txLost)
  );

  clock_watch #(
    .LIMIT_W      (8),
    .STALL_CYCLES (STALL_CYCLES)
  ) u_ref_watch (
    .clk       (clk),
    .reset     (reset),
    .ownEdge   (refRise),
    .otherEdge (txFall),
    .limit     (t1e1_pkg::REF_LOSS_LIMIT),
    .lost      (refLost)
  );

  wire lostCond  = refLost || (txLost && !remoteLoop); // R8 R14
  wire fourEdges = txEdgeCnt_ff == t1e1_pkg::RELEASE_EDGES;
  wire clocksOk  = !refLost && fourEdges;

  always_comb begin
    nxt_drvState = drvState_ff;
    case (drvState_ff)
      t1e1_pkg::DRV_HOLD: begin
        if (clocksOk && (!regMode || cfgWritten_ff)) begin
          nxt_drvState = t1e1_pkg::DRV_ON; // R13
        end
      end
      t1e1_pkg::DRV_ON: begin
        if (lostCond) begin
          nxt_drvState = t1e1_pkg::DRV_LOST; // R8
        end
      end
      t1e1_pkg::DRV_LOST: begin
        if (clocksOk) begin
          nxt_drvState = t1e1_pkg::DRV_ON; // R12
        end
      end
      default: nxt_drvState = t1e1_pkg::DRV_HOLD;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      drvState_ff  <= t1e1_pkg::DRV_HOLD;
      txEdgeCnt_ff <= 3'h0;
      clockLost_ff <= 1'b0;
      driverEn_ff  <= 1'b0;
    end else begin
      drvState_ff <= nxt_drvState;
      if (txLost && !txFall) begin
        txEdgeCnt_ff <= 3'h0;
      end else if (txFall && !fourEdges) begin
        txEdgeCnt_ff <= txEdgeCnt_ff + 3'h1; // R12
      end
      clockLost_ff <= drvState_ff == t1e1_pkg::DRV_LOST; // R11
      driverEn_ff  <= drvState_ff == t1e1_pkg::DRV_ON &&
                      !cfgDec.hiZ && !cfgDec.reserved; // R4 R8
    end
  end

  // ==========================================================================
  // Transmit data capture, settling and decoded outputs
  logic       linePos_ff;
  logic       lineNeg_ff;
  logic       txAlt_ff;
  logic [7:0] settleCnt_ff;
  logic [WIDX_W-1:0] wavePhase_ff;
  logic [7:0] waveSample_ff;
  logic [3:0] pulse_ff;
  logic [8:0] width_ff;
  logic       slice_ff;
  logic       b8zs_ff;
  logic       arb_ff;
  logic [1:0] ja_ff;

  wire settleLoad = txCtrl != txCtrlLast_ff;
  wire [7:0] settleLen = remoteLoop ? t1e1_pkg::SETTLE_RLOOP_BITS
                                    : t1e1_pkg::SETTLE_BITS; // R15 R16

  always_ff @(posedge clk) begin
    if (reset) begin
      linePos_ff    <= 1'b0;
      lineNeg_ff    <= 1'b0;
      txAlt_ff      <= 1'b0;
      txCtrlLast_ff <= '0;
      settleCnt_ff  <= 8'h00;
      wavePhase_ff  <= '0;
    end else begin
      txCtrlLast_ff <= txCtrl;
      if (txFall) begin
        txAlt_ff   <= !txAlt_ff;
        linePos_ff <= txCtrl.transmit_all_ones ? txAlt_ff : txPosS; // R1
        lineNeg_ff <= txCtrl.transmit_all_ones ? !txAlt_ff : txNegS; // R1
      end
      if (settleLoad) begin
        settleCnt_ff <= settleLen; // R15
      end else if (txFall && settleCnt_ff != 8'h00) begin
        settleCnt_ff <= settleCnt_ff - 8'h01;
      end
      if (txFall && cfgDec.arbitrary && regMode) begin
        wavePhase_ff <= wavePhase_ff + 1'b1; // R7
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pulse_ff      <= t1e1_pkg::PULSE_OFF;
      width_ff      <= 9'h000;
      slice_ff      <= 1'b0;
      b8zs_ff       <= 1'b0;
      arb_ff        <= 1'b0;
      ja_ff         <= 2'h0;
      waveSample_ff <= 8'h00;
    end else begin
      pulse_ff      <= cfgDec.pulse; // R3 R4
      width_ff      <= cfgDec.widthNs;
      slice_ff      <= cfgDec.slice65; // R5
      b8zs_ff       <= cfgDec.b8zs;
      arb_ff        <= cfgDec.arbitrary && regMode; // R7
      ja_ff         <= jaLoc;
      waveSample_ff <= waveMem[wavePhase_ff];
    end
  end

  // ==========================================================================
  // Receive data retiming; zero runs pass untouched so the far end sees them
  logic rxClk_ff;
  logic rxPos_ff;
  logic rxNeg_ff;
  logic rxAlt_ff;

  wire rxUpd = edgeSel ? rxRise : rxFall; // R19

  always_ff @(posedge clk) begin
    if (reset) begin
      rxClk_ff <= 1'b0;
      rxPos_ff <= 1'b0;
      rxNeg_ff <= 1'b0;
      rxAlt_ff <= 1'b0;
    end else begin
      rxClk_ff <= rxClkS;
      if (rxUpd) begin
        rxAlt_ff <= !rxAlt_ff;
        rxPos_ff <= allOnes ? rxAlt_ff : rxPosS; // R17 R20
        rxNeg_ff <= allOnes ? !rxAlt_ff : rxNegS; // R20
      end
    end
  end

  // ==========================================================================
  // Outputs
  assign status = {2'h0, txLost, refLost, regMode, driverEn_ff,
                   settleCnt_ff != 8'h00, clockLost_ff};
  assign readdata                = readdata_ff;
  assign waitrequest             = waitreq_ff;
  assign linePositive            = linePos_ff;
  assign lineNegative            = lineNeg_ff;
  assign lineDriverOutputsEnable = driverEn_ff;
  assign pulseShape              = pulse_ff;
  assign pulseWidthNs            = width_ff;
  assign sliceLevel65            = slice_ff;
  assign coderB8zs               = b8zs_ff;
  assign arbitraryWave           = arb_ff;
  assign waveSample              = waveSample_ff;
  assign jitterFilterLocation    = ja_ff;
  assign txSettling              = settleCnt_ff != 8'h00;
  assign clockLostFlag           = clockLost_ff;
  assign rxClockOut              = rxClk_ff;
  assign rxPositiveRailData      = rxPos_ff;
  assign rxNegativeRailData      = rxNeg_ff;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_tx_capture: assert property (txFall && !txCtrl.transmit_all_ones |=>
    linePos_ff == $past(txPosS) && lineNeg_ff == $past(txNegS)) // R1
    else $error("transmit data not captured on falling edge");

  a_slice_level: assert property (
    txCtrl.code inside {4'h2, 4'h7, 4'hc, 4'hf} |=> slice_ff) // R5
    else $error("slicing level not 65 percent");

  a_lost_tristate: assert property (
    drvState_ff != t1e1_pkg::DRV_ON |=> !driverEn_ff) // R8
    else $error("driver enabled while not in run state");

  a_tx_loss_fast: assert property ($rose(txLost) && !remoteLoop &&
    drvState_ff == t1e1_pkg::DRV_ON |=> ##1 !driverEn_ff) // R10
    else $error("driver not tristated after transmit clock loss");

  a_release_four: assert property (drvState_ff == t1e1_pkg::DRV_LOST &&
    txEdgeCnt_ff < 3'd4 |=> drvState_ff != t1e1_pkg::DRV_ON) // R12
    else $error("driver released before four clock cycles");

  a_hold_rewrite: assert property (regMode && !cfgWritten_ff &&
    drvState_ff == t1e1_pkg::DRV_HOLD |=> ##1 !driverEn_ff) // R13
    else $error("driver enabled without configuration rewrite");

  a_rloop_keep: assert property (remoteLoop && !refLost && // R14
    drvState_ff == t1e1_pkg::DRV_ON |=> drvState_ff == t1e1_pkg::DRV_ON)
    else $error("remote loopback tristated on transmit clock loss");

  a_settle_load: assert property (settleLoad && !remoteLoop |=>
    settleCnt_ff == 8'd22 ##1 settleCnt_ff <= 8'd22) // R15
    else $error("settling interval not loaded with 22");

  a_rx_edge: assert property (!rxUpd |=> $stable(rxPos_ff)) // R19
    else $error("receive data changed off its update edge");

  a_all_ones: assert property (allOnes && rxUpd |=>
    rxPos_ff != rxNeg_ff) // R20
    else $error("forced all-ones receive output missing");

endmodule // t1e1_line_tx_rx_control

// [t1e1_pkg.sv]
// Shared constants and types for the line transmit/receive control block.
package t1e1_pkg;

  // ==========================================================================
  // Register map (byte addresses) and field positions
  localparam logic [4:0] CTRL_A_OFS    = 5'h00;
  localparam logic [4:0] CTRL_B_OFS    = 5'h04;
  localparam logic [4:0] STATUS_OFS    = 5'h08;
  localparam logic [4:0] WAVE_IDX_OFS  = 5'h0c;
  localparam logic [4:0] WAVE_DATA_OFS = 5'h10;

  localparam int A_EDGE_BIT = 0;
  localparam int A_JA_LSB   = 1;
  localparam int A_RLA_BIT  = 3;
  localparam int A_RLB_BIT  = 4;
  localparam int B_CODE_LSB = 0;
  localparam int B_TRANSMIT_ALL_ONES_BIT = 4;
  localparam int B_LLA_BIT  = 5;
  localparam int B_LLB_BIT  = 6;

  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h0f;

  // ==========================================================================
  // Counts in transmit or reference clock edges
  localparam logic [7:0] LOSS_LIMIT_JA     = 8'd176;
  localparam logic [7:0] LOSS_LIMIT_DIRECT = 8'd8;
  localparam logic [7:0] REF_LOSS_LIMIT    = 8'd8;
  localparam logic [2:0] RELEASE_EDGES     = 3'd4;
  localparam logic [7:0] SETTLE_BITS       = 8'd22;
  localparam logic [7:0] SETTLE_RLOOP_BITS = 8'd88;

  // ==========================================================================
  // Pulse widths in nanoseconds
  localparam logic [8:0] PW_E1_NS   = 9'd244;
  localparam logic [8:0] PW_DS1_NS  = 9'd324;
  localparam logic [8:0] PW_DSX1_NS = 9'd350;

  // ==========================================================================
  // Types
  typedef enum logic [3:0] {
    PULSE_E1   = 4'h1,
    PULSE_DS1  = 4'h2,
    PULSE_DSX1 = 4'h4,
    PULSE_OFF  = 4'h8
  } pulse_t;

  typedef enum logic [2:0] {
    DRV_HOLD = 3'h1,
    DRV_ON   = 3'h2,
    DRV_LOST = 3'h4
  } drv_state_t;

  typedef enum logic [1:0] {
    JA_RX      = 2'h0,
    JA_OFF     = 2'h1,
    JA_TX      = 2'h2,
    JA_RX_SLOW = 2'h3
  } ja_loc_t;

  typedef struct packed {
    pulse_t     pulse;
    logic [8:0] widthNs;
    logic       slice65;
    logic       b8zs;
    logic       arbitrary;
    logic       hiZ;
    logic       reserved;
  } line_cfg_t;

  typedef struct packed {
    logic [3:0] code;
    logic       transmit_all_ones;
    logic       llbA;
    logic       llbB;
  } tx_ctrl_t;

endpackage

// [config_decode.sv]
// Decoder from the 4-bit line configuration code to line settings.
`timescale 1ns/1ps
module config_decode (
  // Code in
  input  wire logic [3:0]          code,
  // Decoded settings out
  output t1e1_pkg::line_cfg_t      cfg
);

  // ==========================================================================
  // Decode table
  function automatic t1e1_pkg::line_cfg_t decode(input logic [3:0] c);
    t1e1_pkg::line_cfg_t d;
    d = '{t1e1_pkg::PULSE_OFF, 9'h000, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    case (c)
      4'h0, 4'h1, 4'h8, 4'h9: begin // R3
        d = '{t1e1_pkg::PULSE_E1, t1e1_pkg::PW_E1_NS,
              1'b0, 1'b0, c[3], 1'b0, 1'b0};
      end
      4'h7, 4'hc, 4'hb: begin // R3
        d = '{t1e1_pkg::PULSE_DS1, t1e1_pkg::PW_DS1_NS,
              1'b1, 1'b1, c == 4'hb, 1'b0, 1'b0};
      end
      4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'ha: begin // R4
        d = '{t1e1_pkg::PULSE_DSX1, t1e1_pkg::PW_DSX1_NS,
              1'b1, 1'b1, c == 4'ha, 1'b0, 1'b0};
      end
      4'he: d.slice65 = 1'b0; // R4 R5
      4'hf: begin // R4 R5
        d.slice65 = 1'b1;
        d.b8zs    = 1'b1;
      end
      default: d.reserved = 1'b1; // R4
    endcase
    return d;
  endfunction

  assign cfg = decode(code); // R2

endmodule // config_decode

// [clock_watch.sv]
// Watchdog that flags one sampled clock as missing.
`timescale 1ns/1ps
module clock_watch #(
  parameter int LIMIT_W      = 8,
  parameter int STALL_CYCLES = 4096
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // Edges of the watched clock and of the opposite clock
  input  wire logic               ownEdge,
  input  wire logic               otherEdge,
  input  wire logic [LIMIT_W-1:0] limit,
  // Loss indication
  output logic                    lost
);

  localparam int STALL_W = $clog2(STALL_CYCLES + 1);

  if (LIMIT_W < 2 || STALL_CYCLES < 2) begin : g_bad_param
    $error("clock_watch parameters out of range");
  end

  logic [LIMIT_W-1:0] edgeCnt_ff;
  logic [STALL_W-1:0] stallCnt_ff;
  logic               lost_ff;

  wire edgeMax  = &edgeCnt_ff;
  wire stallHit = stallCnt_ff >= STALL_W'(STALL_CYCLES);

  // Counting is done in edges of the opposite clock, so a stopped clock is
  // seen as long as the other one runs; the stall count is the backstop for
  // both clocks stopping together.
  always_ff @(posedge clk) begin
    if (reset) begin
      edgeCnt_ff  <= '0;
      stallCnt_ff <= '0;
      lost_ff     <= 1'b1;
    end else if (ownEdge) begin
      edgeCnt_ff  <= '0;
      stallCnt_ff <= '0;
      lost_ff     <= 1'b0;
    end else begin
      edgeCnt_ff  <= edgeCnt_ff + LIMIT_W'(otherEdge && !edgeMax); // R23
      stallCnt_ff <= otherEdge ? '0 : stallCnt_ff + STALL_W'(!stallHit); // R9
      lost_ff     <= lost_ff || edgeCnt_ff >= limit || stallHit; // R8
    end
  end

  assign lost = lost_ff;

endmodule // clock_watch

// [framer_model.sv]
// System-side framer model: transmit clock, rails and reference clock.
`timescale 1ns/1ps
module framer_model (
  // Control
  input  wire logic run,
  input  wire logic pos,
  // Link
  output logic      txClk,
  output logic      txPos,
  output logic      txNeg,
  output logic      reference_clock_in
);
  initial begin
    txClk = 1'b0;
    reference_clock_in = 1'b0;
    txPos = 1'b0;
    txNeg = 1'b1;
  end
  always #32 reference_clock_in = ~reference_clock_in;
  // Rails change at the rising edge so they are steady at the falling edge.
  always #32 if (run) begin
    txClk = ~txClk;
    if (txClk) txPos = pos;
    if (txClk) txNeg = ~pos;
  end
endmodule // framer_model

// [t1e1_line_tx_rx_control_bench.sv]
// Self-checking bench for the line transmit/receive control block.
`timescale 1ns/1ps
module t1e1_line_tx_rx_control_bench;
  logic clk = 0, reset = 1, read = 0, write = 0, run = 0, pos = 0;
  logic regMode = 0, local_loopback = 0, rLoop = 0, edgeSel = 0, s;
  logic [4:0] address = 0;
  logic [31:0] writedata = 0, q;
  logic [3:0] code = 4'h0;
  logic [1:0] jLoc = 2'h1;
  logic [10:0] e;
  wire logic [31:0] readdata;
  wire logic waitrequest, txClk, txPos, txNeg, reference_clock_in, en, lost, settle;
  wire logic linePos, lineNeg, rxPos, slice, b8zs;
  wire logic [8:0] width;
  wire logic [1:0] ja;
  int errors = 0, n_checks = 0, cyc = 0;
  always #2.5 clk = ~clk;
  framer_model fm (.run(run), .pos(pos), .txClk(txClk), .txPos(txPos),
    .txNeg(txNeg), .reference_clock_in(reference_clock_in));
  t1e1_line_tx_rx_control #(.STALL_CYCLES(64)) dut (.clk(clk), .reset(reset),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .registerModePin(regMode),
    .lineConfigCodePin(code), .rxEdgeSelectPin(edgeSel),
    .jitterFilterLocationPin(jLoc), .transmitAllOnesPin(1'b0),
    .localLoopbackPin(local_loopback), .remoteLoopbackPin(rLoop), .txLineClock(txClk),
    .txPositiveRailData(txPos), .txNegativeRailData(txNeg),
    .referenceClockIn(reference_clock_in), .linePositive(linePos), .lineNegative(lineNeg),
    .lineDriverOutputsEnable(en), .pulseShape(), .pulseWidthNs(width),
    .sliceLevel65(slice), .coderB8zs(b8zs), .arbitraryWave(), .waveSample(),
    .jitterFilterLocation(ja), .txSettling(settle), .clockLostFlag(lost),
    .rxRecoveredClock(txClk), .rxPositiveIn(1'b1), .rxNegativeIn(1'b0),
    .rxClockOut(), .rxPositiveRailData(rxPos), .rxNegativeRailData());
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] y);
    n_checks++;
    if (y !== x) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, x, y);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= w;
    read <= ~w;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic t_link;
    for (int i = 0; i < 2; i++) begin
      pos <= i[0];
      wt(60);
      chk("rails", {i[0], ~i[0]}, {linePos, lineNeg});
    end
  endtask
  task automatic t_decode;
    for (int c = 0; c < 16; c++) begin
      code <= c[3:0];
      wt(8);
      e = (c < 2 || c == 8 || c == 9) ? 11'h3d0 :
          (c == 7 || c == 11 || c == 12) ? 11'h513 :
          (c < 7 || c == 10) ? 11'h57b : (c == 15) ? 11'h3 : 11'h0;
      if (c != 13) chk("decode", e, {width, slice, b8zs});
    end
  endtask
  task automatic t_loss;
    run <= 1'b0;
    wt(51);
    chk("early", 1, en);
    wt(103);
    chk("stopped", 0, en);
    chk("lostflag", 1, lost);
    run <= 1'b1;
    wt(80);
    chk("resumed", 2'b10, {en, lost});
  endtask
  task automatic t_keep;
    jLoc <= 2'h2;
    wt(8);
    chk("jaloc", 2'h2, ja);
    for (int k = 0; k < 2; k++) begin
      rLoop <= k[0];
      wt(8);
      run <= 1'b0;
      wt(154);
      chk("kept", 2'b10, {en, lost});
      run <= 1'b1;
      wt(80);
      jLoc <= 2'h1;
    end
    rLoop <= 1'b0;
  endtask
  task automatic t_settle;
    code <= 4'h2;
    wt(8);
    chk("settling", 1, settle);
    wt(320);
    chk("settled", 0, settle);
  endtask
  task automatic t_regs;
    regMode <= 1'b1;
    wt(8);
    bus(1'b0, 5'h04, 0);
    chk("ctrlB", 32'h0f, q);
    bus(1'b0, 5'h14, 0);
    chk("unmapped", 0, q);
    bus(1'b1, 5'h04, 32'h60);
    bus(1'b0, 5'h08, 0);
    chk("regmode", 1, q[3]);
    chk("regwidth", 244, width);
    @(posedge txClk);
    wt(6);
    s = rxPos;
    @(posedge txClk);
    wt(6);
    chk("allones", {~s}, rxPos);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    wt(16);
    reset <= 1'b0;
    wt(1);
    chk("idle", 2'b10, {waitrequest, en});
    run <= 1'b1;
    wt(300);
    chk("enabled", 1, en);
    t_link();
    t_decode();
    code <= 4'h0;
    wt(300);
    t_settle();
    t_loss();
    t_keep();
    t_regs();
    stop_test();
  end
endmodule // t1e1_line_tx_rx_control_bench
